// [core/psc_top.sv]
// Purpose: SMI source gating, cause status and clock-halt sequencing behind an APB slave.
// Assumes: Access and timer events are one-cycle pulses on pclk; pins are asynchronous.
// Notes: Zero wait-state APB; read data is captured in the setup cycle.
//
// Chosen here: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module psc_top #(
  parameter int DLY0_CYC = psc_pkg::DLY0_CYC,
  parameter int DLY1_CYC = psc_pkg::DLY1_CYC,
  parameter int DLY2_CYC = psc_pkg::DLY2_CYC,
  parameter int DLY3_CYC = psc_pkg::DLY3_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [psc_pkg::ADDR_W-1:0] paddr,
  input wire logic [psc_pkg::DATA_W-1:0] pwdata,
  output logic [psc_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] access_event,
  input wire logic [7:0] timer_trap_event,
  input wire logic user_timer3_timeout,
  input wire logic sw_smi_request,
  input wire logic apm_command_port,
  input wire logic apm_control_read,
  input wire logic standby_event,
  input wire logic external_pm_request_pin,
  input wire logic dma_enabled_req,
  input wire logic irq_enabled_req,
  input wire logic [7:0] irq_line,
  input wire logic cpu_interrupt_request,
  output logic system_mgmt_interrupt,
  output logic cpu_clock_halt
);
  import psc_pkg::*;

  psc_state_s s_q;
  psc_state_s s_d;
  logic [7:0] idx;
  logic hit;
  logic wr;
  logic rd;
  logic pm_on;
  logic [ASYNC_W-1:0] rise;
  logic [7:0] acc_set;
  logic [7:0] tmr_set;
  logic [7:0] misc_set;
  logic [7:0] irq_set;
  logic [7:0] rdv;
  logic pending;
  logic trigger;
  logic release_ev;
  logic stay;
  logic [CNT_W-1:0] dly_load;

  assign idx = paddr[9:2];
  assign wr = psel & penable & pwrite & ~s_q.pslverr;
  assign rd = psel & penable & ~pwrite & ~s_q.pslverr;
  assign pready = psel & penable;
  assign prdata = s_q.prdata;
  assign pslverr = s_q.pslverr & psel & penable;
  assign system_mgmt_interrupt = s_q.smi;
  assign cpu_clock_halt = s_q.halt;
  assign pm_on = s_q.pm_ctrl[PM_EN_BIT];

  always_comb begin
    hit = 1'b1;
    rdv = 8'h00;
    case (idx)
      IDX_PM_CTRL: rdv = s_q.pm_ctrl;
      IDX_CLK_STOP: rdv = s_q.cs_ctrl;
      IDX_SMI_FORCE: rdv = s_q.smi_frc;
      IDX_ACC_EN: rdv = s_q.acc_en;
      IDX_TMR_EN: rdv = s_q.tmr_en;
      IDX_MISC_EN: rdv = s_q.misc_en;
      IDX_IRQ_EN: rdv = s_q.irq_en;
      IDX_ACC_ST: rdv = s_q.acc_st;
      IDX_TMR_ST: rdv = s_q.tmr_st;
      IDX_MISC_ST: rdv = s_q.misc_st;
      IDX_IRQ_ST: rdv = s_q.irq_st;
      default: hit = 1'b0;
    endcase
    if (paddr[11:10] != 2'b00 || paddr[1:0] != 2'b00) begin
      hit = 1'b0;
    end
  end

  always_comb begin
    case (s_q.cs_ctrl[CS_SEL_LSB +: 2])
      2'b00: dly_load = CNT_W'(DLY0_CYC - 1);
      2'b01: dly_load = CNT_W'(DLY1_CYC - 1);
      2'b10: dly_load = CNT_W'(DLY2_CYC - 1);
      default: dly_load = CNT_W'(DLY3_CYC - 1);
    endcase
  end

  always_comb begin
    s_d = s_q;
    // Only the second and third stages are compared; the first stage feeds nothing else.
    s_d.sync1 = {external_pm_request_pin, dma_enabled_req, irq_enabled_req,
                 irq_line[7:3], cpu_interrupt_request, irq_line[1:0]};
    s_d.sync2 = s_q.sync1;
    s_d.sync3 = s_q.sync2;
    for (int i = 0; i < ASYNC_W; i++) begin
      if (s_q.sync2[i] == s_q.sync3[i]) begin
        s_d.stable[i] = s_q.sync2[i];
      end
    end
    rise = s_d.stable & ~s_q.stable;

    acc_set = pm_on ? (access_event & s_q.acc_en) : 8'h00;
    tmr_set = pm_on ? (timer_trap_event & s_q.tmr_en) : 8'h00;
    misc_set = 8'h00;
    if (pm_on) begin
      misc_set[5] = rise[DMA_I] & s_q.misc_en[5];
      misc_set[4] = rise[IRQA_I] & s_q.misc_en[4];
      misc_set[3] = rise[EXT_I] & s_q.misc_en[3];
      misc_set[2] = apm_command_port & s_q.misc_en[2];
      misc_set[1] = sw_smi_request & s_q.misc_en[1];
      misc_set[0] = user_timer3_timeout & s_q.misc_en[0];
    end
    irq_set = pm_on ? (rise[7:0] & s_q.irq_en) : 8'h00;

    // Setting wins over a same-cycle clear so no cause is lost.
    s_d.acc_st = (s_q.acc_st & ~((wr && idx == IDX_ACC_ST) ? pwdata[7:0] : 8'h00))
                 | acc_set;
    s_d.tmr_st = (s_q.tmr_st & ~((wr && idx == IDX_TMR_ST) ? pwdata[7:0] : 8'h00)
                  & ~((rd && idx == IDX_TMR_ST) ? TRAP_MASK : 8'h00)) | tmr_set;
    s_d.misc_st = (s_q.misc_st & ~((wr && idx == IDX_MISC_ST) ? pwdata[7:0] : 8'h00))
                  | misc_set;
    s_d.irq_st = (s_q.irq_st & ~((wr && idx == IDX_IRQ_ST) ? pwdata[7:0] : 8'h00))
                 | irq_set;

    if (wr) begin
      case (idx)
        IDX_PM_CTRL: s_d.pm_ctrl = pwdata[7:0] & PM_WMASK;
        IDX_CLK_STOP: s_d.cs_ctrl = pwdata[7:0] & CS_WMASK;
        IDX_SMI_FORCE: s_d.smi_frc = pwdata[7:0] & FRC_WMASK;
        IDX_ACC_EN: s_d.acc_en = pwdata[7:0];
        IDX_TMR_EN: s_d.tmr_en = pwdata[7:0];
        IDX_MISC_EN: s_d.misc_en = pwdata[7:0] & MISC_WMASK;
        IDX_IRQ_EN: s_d.irq_en = pwdata[7:0];
        default: s_d.pm_ctrl = s_q.pm_ctrl;
      endcase
    end

    if (psel && !penable) begin
      s_d.prdata = {24'h000000, rdv};
      s_d.pslverr = ~hit;
    end

    pending = |(s_q.acc_st & s_q.acc_en) | |(s_q.tmr_st & s_q.tmr_en)
              | |(s_q.misc_st & s_q.misc_en & MISC_WMASK) | |(s_q.irq_st & s_q.irq_en);
    // Force-assert outranks force-deassert when software sets both.
    s_d.smi = s_q.smi_frc[FRC_ON_BIT]
              | (~s_q.smi_frc[FRC_OFF_BIT] & pm_on & pending);

    trigger = pm_on & s_q.cs_ctrl[CS_EN_BIT] & s_q.misc_en[MISC_HALT_BIT]
              & apm_control_read;
    release_ev = standby_event & ~s_q.cs_ctrl[CS_KEEP_BIT];
    stay = pm_on & s_q.cs_ctrl[CS_EN_BIT] & ~release_ev;
    case (s_q.state)
      ST_IDLE: begin
        if (trigger && s_q.cs_ctrl[CS_DLY_BIT]) begin
          s_d.state = ST_DELAY;
          s_d.cnt = dly_load;
        end else if (trigger) begin
          s_d.state = ST_HALT;
          s_d.cnt = CNT_W'(THR_HALT_CYC - 1);
        end
      end
      ST_DELAY: begin
        if (!stay) begin
          s_d.state = ST_IDLE;
        end else if (s_q.cnt == '0) begin
          s_d.state = ST_HALT;
          s_d.cnt = CNT_W'(THR_HALT_CYC - 1);
        end else begin
          s_d.cnt = s_q.cnt - 1'b1;
        end
      end
      ST_HALT: begin
        if (!stay) begin
          s_d.state = ST_IDLE;
        end else if (s_q.cs_ctrl[CS_THR_BIT] && s_q.cnt == '0) begin
          s_d.state = ST_RUN;
          s_d.cnt = CNT_W'(THR_RUN_CYC - 1);
        end else if (s_q.cs_ctrl[CS_THR_BIT]) begin
          s_d.cnt = s_q.cnt - 1'b1;
        end
      end
      ST_RUN: begin
        if (!stay) begin
          s_d.state = ST_IDLE;
        end else if (!s_q.cs_ctrl[CS_THR_BIT] || s_q.cnt == '0) begin
          s_d.state = ST_HALT;
          s_d.cnt = CNT_W'(THR_HALT_CYC - 1);
        end else begin
          s_d.cnt = s_q.cnt - 1'b1;
        end
      end
      default: s_d.state = ST_IDLE;
    endcase
    s_d.halt = (s_d.state == ST_HALT);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  force_assert_a: assert property (s_q.smi_frc[FRC_ON_BIT] |=> system_mgmt_interrupt)
    else $error("forced SMI not active");
  force_deassert_a: assert property (
    !s_q.smi_frc[FRC_ON_BIT] && s_q.smi_frc[FRC_OFF_BIT] |=> !system_mgmt_interrupt)
    else $error("SMI active while forced off");
  pm_gate_a: assert property (
    !pm_on && !s_q.smi_frc[FRC_ON_BIT] |=> !system_mgmt_interrupt && s_q.state == ST_IDLE)
    else $error("activity while power management disabled");
  halt_enable_a: assert property (!s_q.cs_ctrl[CS_EN_BIT] |=> !cpu_clock_halt)
    else $error("clock halt without enable");
  apm_halt_a: assert property (
    trigger && !s_q.cs_ctrl[CS_DLY_BIT] && s_q.state == ST_IDLE |=> cpu_clock_halt)
    else $error("APM read did not halt clock");
  delay_hold_a: assert property (
    trigger && s_q.cs_ctrl[CS_DLY_BIT] && s_q.state == ST_IDLE
    |=> s_q.state == ST_DELAY && s_q.cnt == dly_load && !cpu_clock_halt ##1 !cpu_clock_halt[*8])
    else $error("delay not applied before halt");
  standby_rel_a: assert property (
    s_q.state != ST_IDLE && standby_event && !s_q.cs_ctrl[CS_KEEP_BIT] |=> !cpu_clock_halt)
    else $error("standby did not release halt");
  standby_keep_a: assert property (
    cpu_clock_halt && stay && standby_event && !s_q.cs_ctrl[CS_THR_BIT] |=> cpu_clock_halt)
    else $error("standby released a kept halt");
  throttle_a: assert property (
    s_q.state == ST_HALT && stay && s_q.cs_ctrl[CS_THR_BIT] && s_q.cnt == '0
    |=> !cpu_clock_halt)
    else $error("throttle did not toggle halt");
  cause_set_a: assert property (|acc_set |=> (s_q.acc_st & $past(acc_set)) == $past(acc_set))
    else $error("access cause bit not set");

  // Without a write to the access status register, no pending access cause may drop.
  acc_keep_a: assert property (
    !(wr && idx == IDX_ACC_ST)
    |=> (s_q.acc_st & $past(s_q.acc_st)) == $past(s_q.acc_st))
    else $error("access cause bit lost without a clear");

  acc_clear_a: assert property (
    wr && idx == IDX_ACC_ST && acc_set == 8'h00
    |=> (s_q.acc_st & $past(pwdata[7:0])) == 8'h00)
    else $error("access cause bit not cleared by a one");

  tmr_cause_a: assert property (
    |tmr_set
    |=> (s_q.tmr_st & $past(tmr_set)) == $past(tmr_set))
    else $error("timer cause bit not set");

  misc_cause_a: assert property (
    |misc_set
    |=> (s_q.misc_st & $past(misc_set)) == $past(misc_set))
    else $error("misc cause bit not set");

  irq_cause_a: assert property (
    |irq_set
    |=> (s_q.irq_st & $past(irq_set)) == $past(irq_set))
    else $error("interrupt cause bit not set");

  // Trap causes clear on a read, but a trap arriving in that cycle must survive.
  trap_rdclr_a: assert property (
    rd && idx == IDX_TMR_ST && (tmr_set & TRAP_MASK) == 8'h00
    |=> (s_q.tmr_st & TRAP_MASK) == 8'h00)
    else $error("trap cause not cleared by read");

  pm_off_cause_a: assert property (
    !pm_on
    |=> (s_q.acc_st & ~$past(s_q.acc_st)) == 8'h00
        && (s_q.irq_st & ~$past(s_q.irq_st)) == 8'h00
        && (s_q.misc_st & ~$past(s_q.misc_st)) == 8'h00)
    else $error("cause set while power management disabled");

  smi_source_a: assert property (
    pm_on && pending && !s_q.smi_frc[FRC_OFF_BIT]
    |=> system_mgmt_interrupt)
    else $error("pending cause did not raise SMI");

  smi_quiet_a: assert property (
    !pending && !s_q.smi_frc[FRC_ON_BIT]
    |=> !system_mgmt_interrupt)
    else $error("SMI active with nothing pending");

  // Only the request sources in the synchroniser may form an edge, never a glitch.
  rise_sync_a: assert property (
    (rise & ~(s_q.sync2 & s_q.sync3)) == '0)
    else $error("edge taken before the synchroniser agreed");

  idle_stay_a: assert property (
    s_q.state == ST_IDLE && !trigger
    |=> !cpu_clock_halt)
    else $error("clock halt without a control port read");

  delay_count_a: assert property (
    s_q.state == ST_DELAY && stay && s_q.cnt != '0
    |=> s_q.state == ST_DELAY && s_q.cnt == $past(s_q.cnt) - 1'b1)
    else $error("assertion delay did not count down");

  delay_end_a: assert property (
    s_q.state == ST_DELAY && stay && s_q.cnt == '0
    |=> cpu_clock_halt)
    else $error("halt not raised when the delay ran out");

  halt_hold_a: assert property (
    s_q.state == ST_HALT && stay && !s_q.cs_ctrl[CS_THR_BIT]
    |=> cpu_clock_halt)
    else $error("halt dropped without throttling");

  halt_len_a: assert property (
    s_q.state != ST_HALT ##1 s_q.state == ST_HALT
    |-> s_q.cnt == CNT_W'(THR_HALT_CYC - 1))
    else $error("halt phase length not loaded");

  run_hold_a: assert property (
    s_q.state == ST_RUN && stay && s_q.cs_ctrl[CS_THR_BIT] && s_q.cnt != '0
    |=> !cpu_clock_halt)
    else $error("run phase cut short");

  run_end_a: assert property (
    s_q.state == ST_RUN && stay && (s_q.cnt == '0 || !s_q.cs_ctrl[CS_THR_BIT])
    |=> cpu_clock_halt)
    else $error("run phase did not return to halt");

  smi_seen_c: cover property (!system_mgmt_interrupt ##1 system_mgmt_interrupt);
  delay_done_c: cover property (s_q.state == ST_DELAY ##1 s_q.state == ST_HALT);
  throttle_c: cover property (s_q.state == ST_RUN ##1 s_q.state == ST_HALT);
  force_on_c: cover property (s_q.smi_frc[FRC_ON_BIT] ##1 system_mgmt_interrupt);
  standby_rel_c: cover property (cpu_clock_halt && standby_event ##1 !cpu_clock_halt);
endmodule : psc_top
`default_nettype wire

// [dv/pm_smi_cpu_clock_halt_control_test.sv]
// Purpose: Self-checking bench for the SMI and clock-halt controller.
// Assumes: Delay parameters shrunk to short counts so every code runs quickly.
// Notes: SMI and halt are sampled on the falling edge, bus read data on the rising edge; inputs change after the rising edge.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_errors++; \
  $display("Error at %0t: got %0h expected %0h", $time, (a), (b)); end end
module pm_smi_cpu_clock_halt_control_test;
  import psc_pkg::*;
  localparam int DLY [4] = '{20, 30, 40, 50};
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, apm_rd = 1'b0, stby = 1'b0;
  logic [ADDR_W-1:0] paddr = 12'h000;
  logic [DATA_W-1:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, smi, halt, er;
  logic [7:0] acc = 8'h00, tt = 8'h00, irql = 8'h00;
  logic [5:0] msc = 6'h00;
  logic [7:0] st [4] = '{IDX_ACC_ST, IDX_TMR_ST, IDX_MISC_ST, IDX_IRQ_ST};
  logic [7:0] ri [6] = '{IDX_CLK_STOP, IDX_SMI_FORCE, IDX_ACC_EN, IDX_TMR_EN, IDX_MISC_EN,
    IDX_IRQ_EN};
  logic [7:0] rm [6] = '{CS_WMASK, FRC_WMASK, 8'hff, 8'hff, MISC_WMASK, 8'hff};
  int n_errors = 0, tests_run = 0, hc, hc0, n;
  always #20 pclk = ~pclk;
  psc_top #(.DLY0_CYC(DLY[0]), .DLY1_CYC(DLY[1]), .DLY2_CYC(DLY[2]), .DLY3_CYC(DLY[3])) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .access_event(acc), .timer_trap_event(tt), .user_timer3_timeout(msc[0]),
    .sw_smi_request(msc[1]), .apm_command_port(msc[2]), .apm_control_read(apm_rd),
    .standby_event(stby), .external_pm_request_pin(msc[3]), .dma_enabled_req(msc[5]),
    .irq_enabled_req(msc[4]), .irq_line(irql), .cpu_interrupt_request(irql[2]),
    .system_mgmt_interrupt(smi), .cpu_clock_halt(halt));
  psc_cpu_model cpu (.pclk(pclk), .presetn(presetn), .halt_in(halt), .halted_cycles(hc));
  task automatic wrap_up();
    $display("Checks run: %0d, mismatches: %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : wrap_up
  // Every bus task is entered just after a rising edge and leaves one edge after release.
  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] wd);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h000000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin
      n_errors++;
      $display("Error at %0t: got %0h expected %0h", $time, pready, 1'b1);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic see(input logic v, input logic on_halt);
    repeat (3) @(negedge pclk);
    `CHK(on_halt ? halt : smi, v)
    @(posedge pclk);
  endtask : see
  task automatic src(input int g, input int b);
    logic [7:0] m;
    int k;
    m = 8'h01 << b;
    apb(1'b1, 8'h70 + 8'(g), m);
    case (g)
      0: acc <= m;
      1: tt <= m;
      2: msc <= m[5:0];
      default: irql <= m;
    endcase
    @(posedge pclk);
    acc <= 8'h00;
    tt <= 8'h00;
    if (g == 2 && b < 3) msc <= 6'h00;
    k = 0;
    do begin
      @(negedge pclk);
      k++;
    end while (smi !== 1'b1 && k < 12);
    `CHK(smi, 1'b1)
    @(posedge pclk);
    apb(1'b0, st[g], 8'h00);
    `CHK(rd[7:0], m)
    apb(1'b1, st[g], m);
    see(1'b0, 1'b0);
    msc <= 6'h00;
    irql <= 8'h00;
    apb(1'b1, 8'h70 + 8'(g), 8'h00);
    repeat (6) @(posedge pclk);
  endtask : src
  task automatic halt_go(input logic [7:0] cs, output int cnt);
    apb(1'b1, IDX_CLK_STOP, cs);
    apm_rd <= 1'b1;
    @(posedge pclk);
    apm_rd <= 1'b0;
    cnt = 1;
    @(negedge pclk);
    while (halt !== 1'b1 && cnt < 60) begin
      @(negedge pclk);
      cnt++;
    end
    @(posedge pclk);
  endtask : halt_go
  task automatic stby_pulse();
    stby <= 1'b1;
    @(posedge pclk);
    stby <= 1'b0;
  endtask : stby_pulse
  initial begin
    repeat (20000) @(posedge pclk);
    n_errors++;
    wrap_up();
  end
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    `CHK({smi, halt}, 2'b00)
    apb(1'b0, IDX_PM_CTRL, 8'h00);
    `CHK(rd, 32'h00000000)
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, st[i], 8'h00);
      `CHK(rd, 32'h00000000)
    end
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, ri[i], 8'h00);
      `CHK(rd, 32'h00000000)
      apb(1'b1, ri[i], 8'hff);
      apb(1'b0, ri[i], 8'h00);
      `CHK(rd, {24'h000000, rm[i]})
      apb(1'b1, ri[i], 8'h00);
    end
    apb(1'b0, 8'h80, 8'h00);
    `CHK({er, rd}, 33'h100000000)
    // Global enable still off: a burst of enabled events must leave no trace.
    apb(1'b1, IDX_ACC_EN, 8'hff);
    acc <= 8'hff;
    @(posedge pclk);
    acc <= 8'h00;
    see(1'b0, 1'b0);
    apb(1'b0, IDX_ACC_ST, 8'h00);
    `CHK(rd, 32'h00000000)
    apb(1'b1, IDX_ACC_EN, 8'h00);
    apb(1'b1, IDX_PM_CTRL, 8'h80);
    for (int g = 0; g < 4; g++) begin
      for (int b = 0; b < ((g == 2) ? 6 : 8); b++) begin
        src(g, b);
      end
    end
    apb(1'b1, IDX_ACC_EN, 8'h01);
    acc <= 8'h01;
    @(posedge pclk);
    acc <= 8'h00;
    apb(1'b1, IDX_SMI_FORCE, 8'h40);
    see(1'b0, 1'b0);
    apb(1'b1, IDX_SMI_FORCE, 8'hc0);
    see(1'b1, 1'b0);
    apb(1'b1, IDX_SMI_FORCE, 8'h00);
    see(1'b1, 1'b0);
    apb(1'b1, IDX_ACC_ST, 8'h01);
    apb(1'b1, IDX_ACC_EN, 8'h00);
    apb(1'b1, IDX_SMI_FORCE, 8'h80);
    see(1'b1, 1'b0);
    apb(1'b1, IDX_SMI_FORCE, 8'h00);
    see(1'b0, 1'b0);
    apb(1'b1, IDX_MISC_EN, 8'h40);
    halt_go(8'h00, n);
    `CHK(n, 60)
    halt_go(8'h80, n);
    `CHK(n, 1)
    stby_pulse();
    see(1'b0, 1'b1);
    halt_go(8'h90, n);
    stby_pulse();
    see(1'b1, 1'b1);
    apb(1'b1, IDX_CLK_STOP, 8'h00);
    see(1'b0, 1'b1);
    for (int c = 0; c < 4; c++) begin
      halt_go(8'h88 | (8'(c) << 1), n);
      `CHK(n >= DLY[c] && n <= DLY[c] + 2, 1'b1)
      apb(1'b1, IDX_CLK_STOP, 8'h00);
      see(1'b0, 1'b1);
    end
    // Any 64-cycle span of a 16-on 16-off pattern holds exactly 32 halted cycles.
    halt_go(8'hc0, n);
    hc0 = hc;
    repeat (64) @(posedge pclk);
    `CHK(hc - hc0, 32)
    apb(1'b1, IDX_CLK_STOP, 8'h00);
    apb(1'b1, IDX_MISC_EN, 8'h00);
    halt_go(8'h80, n);
    `CHK(n, 60)
    wrap_up();
  end
endmodule : pm_smi_cpu_clock_halt_control_test
`default_nettype wire

// [dv/psc_cpu_model.sv]
// Purpose: Processor stand-in that watches the clock-halt line.
// Assumes: The halt line is a registered level on pclk.
// Notes: Counting halted cycles lets the bench judge throttling without phase tricks.
`timescale 1ns/1ps
`default_nettype none
module psc_cpu_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic halt_in,
  output var int halted_cycles
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      halted_cycles <= 0;
    end else if (halt_in) begin
      halted_cycles <= halted_cycles + 1;
    end
  end
endmodule : psc_cpu_model
`default_nettype wire

// [inc/psc_pkg.sv]
// Purpose: Constants, state layout and register map for the SMI and clock-halt controller.
// Assumes: 25 MHz pclk, APB slave with one 8-bit register per 32-bit word.
// Notes: Register byte address is four times the register index.
package psc_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam logic [7:0] IDX_PM_CTRL = 8'h63;
  localparam logic [7:0] IDX_CLK_STOP = 8'h66;
  localparam logic [7:0] IDX_SMI_FORCE = 8'h67;
  localparam logic [7:0] IDX_ACC_EN = 8'h70;
  localparam logic [7:0] IDX_TMR_EN = 8'h71;
  localparam logic [7:0] IDX_MISC_EN = 8'h72;
  localparam logic [7:0] IDX_IRQ_EN = 8'h73;
  localparam logic [7:0] IDX_ACC_ST = 8'h76;
  localparam logic [7:0] IDX_TMR_ST = 8'h77;
  localparam logic [7:0] IDX_MISC_ST = 8'h7a;
  localparam logic [7:0] IDX_IRQ_ST = 8'h7b;
  localparam logic [7:0] PM_WMASK = 8'hef;
  localparam logic [7:0] CS_WMASK = 8'hde;
  localparam logic [7:0] FRC_WMASK = 8'hc0;
  localparam logic [7:0] MISC_WMASK = 8'h7f;
  localparam logic [7:0] TRAP_MASK = 8'h03;
  localparam int PM_EN_BIT = 7;
  localparam int CS_EN_BIT = 7;
  localparam int CS_THR_BIT = 6;
  localparam int CS_KEEP_BIT = 4;
  localparam int CS_DLY_BIT = 3;
  localparam int CS_SEL_LSB = 1;
  localparam int FRC_ON_BIT = 7;
  localparam int FRC_OFF_BIT = 6;
  localparam int MISC_HALT_BIT = 6;
  localparam int ASYNC_W = 11;
  localparam int EXT_I = 10;
  localparam int DMA_I = 9;
  localparam int IRQA_I = 8;
  localparam int CLK_MHZ = 25;
  localparam int DLY0_NS = 430000;
  localparam int DLY1_NS = 860000;
  localparam int DLY2_NS = 1700000;
  localparam int DLY3_NS = 7000000;
  localparam int THR_HALT_NS = 640;
  localparam int THR_RUN_NS = 640;
  localparam int DLY0_CYC = (DLY0_NS * CLK_MHZ + 999) / 1000;
  localparam int DLY1_CYC = (DLY1_NS * CLK_MHZ + 999) / 1000;
  localparam int DLY2_CYC = (DLY2_NS * CLK_MHZ + 999) / 1000;
  localparam int DLY3_CYC = (DLY3_NS * CLK_MHZ + 999) / 1000;
  localparam int THR_HALT_CYC = (THR_HALT_NS * CLK_MHZ + 999) / 1000;
  localparam int THR_RUN_CYC = (THR_RUN_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W = 18;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_DELAY = 2'b01,
    ST_HALT = 2'b10,
    ST_RUN = 2'b11
  } psc_halt_e;

  typedef struct packed {
    logic [7:0] pm_ctrl;
    logic [7:0] cs_ctrl;
    logic [7:0] smi_frc;
    logic [7:0] acc_en;
    logic [7:0] tmr_en;
    logic [7:0] misc_en;
    logic [7:0] irq_en;
    logic [7:0] acc_st;
    logic [7:0] tmr_st;
    logic [7:0] misc_st;
    logic [7:0] irq_st;
    logic [31:0] prdata;
    logic pslverr;
    logic smi;
    logic halt;
    psc_halt_e state;
    logic [CNT_W-1:0] cnt;
    logic [ASYNC_W-1:0] sync1;
    logic [ASYNC_W-1:0] sync2;
    logic [ASYNC_W-1:0] sync3;
    logic [ASYNC_W-1:0] stable;
  } psc_state_s;
endpackage : psc_pkg
